// file: core/cxc_defs.vh
// Constants for the exception check unit: register offsets, fields, vectors and access port codes
`ifndef CXC_DEFS_VH
`define CXC_DEFS_VH

// APB register byte offsets
`define CXC_REG_CTRL      12'h000
`define CXC_REG_STATUS    12'h004
`define CXC_REG_MASK      12'h008
`define CXC_REG_GSTAT     12'h00c
`define CXC_REG_EVENT     12'h010
`define CXC_REG_SAVED_IP  12'h014
`define CXC_REG_LOG_ADDR  12'h018

// Control register fields
`define CXC_CTRL_AM_BIT   0
`define CXC_CTRL_MCE_BIT  1
`define CXC_CTRL_RESET    2'h0

// Global check status fields
`define CXC_GSTAT_SAVED_POINTER_VALID_BIT 0
`define CXC_GSTAT_IP_BIT   1

// Status / mask bit positions
`define CXC_EV_ALIGN      0
`define CXC_EV_MCHK       1
`define CXC_EV_SHUT       2
`define CXC_EV_MASKABLE_INTERRUPT_REQUEST       3
`define CXC_EV_W          4

// Vectors
`define CXC_VEC_ALIGN     8'h11
`define CXC_VEC_MCHK      8'h12
`define CXC_VEC_USER_MIN  8'h20
`define CXC_VEC_USER_MAX  8'hff

// Segment classes on the access port
`define CXC_SEG_DATA      2'h0
`define CXC_SEG_STACK     2'h1
`define CXC_SEG_CODE      2'h2
`define CXC_SEG_SYS       2'h3

// Data type codes on the access port
`define CXC_DT_BYTE       4'h0
`define CXC_DT_WORD       4'h1
`define CXC_DT_DWORD      4'h2
`define CXC_DT_SREAL      4'h3
`define CXC_DT_DREAL      4'h4
`define CXC_DT_XREAL      4'h5
`define CXC_DT_SEL        4'h6
`define CXC_DT_FP32       4'h7
`define CXC_DT_FP48       4'h8
`define CXC_DT_PTR32      4'h9
`define CXC_DT_TBLREG     4'ha
`define CXC_DT_FENV       4'hb
`define CXC_DT_FPU_STATE_SAVE      4'hc
`define CXC_DT_BITSTR     4'hd

// User and kernel privilege levels
`define CXC_CPL_USER      2'h3
`define CXC_CPL_KERNEL    2'h0

// Event log depth
`define CXC_LOG_DEPTH     4
`define CXC_LOG_AW        2

`endif

// file: core/cxc_log_mem.v
// Small event log memory with registered read data
`timescale 1ns/1ps
module cxc_log_mem (
	input  wire        i_clk,
	input  wire        i_we,
	input  wire [1:0]  i_waddr,
	input  wire [39:0] i_wdata,
	input  wire [1:0]  i_raddr,
	output reg  [39:0] o_rdata
);
	reg [39:0] mem [0:3];

	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule

// file: core/cxc_exc_unit.v
// Exception detection for alignment fault, machine error abort and user vectors
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "cxc_defs.vh"

// Overview of operation
// - Only data and stack segment accesses are alignment checked, never code or system ones.
// - An operand is misaligned when its address is not a multiple of 2, 4 or 8 by its type.
// - Selectors and 32-bit far pointers need 2, 48-bit far and 32-bit pointers and table registers need 4.
// - Floating environment, save areas and bit strings need 4 or 2 bytes by operand size.
// - Checking needs mask enable set, the flag register alignment flag set and privilege 3.
// - Implicit privilege 0 accesses never fault on alignment.
// - An alignment fault goes out on vector 17 with error code zero and the faulting pointer.
// - A faulting instruction leaves no architectural effect.
// - A machine error is an abort on vector 18 with no error code.
// - The saved pointer valid flag is set only when the pointer is tied to the error.
// - With machine check enable set a machine error aborts, otherwise the core shuts down.
// - Vectors 32 to 255 come from a software interrupt or the external maskable request.
// - User vectors push no error code and save the pointer of the next instruction.
// - An external request is serviced only after all earlier instructions have retired.
module cxc_exc_unit (
	input  wire        I_CLK_SYS,
	input  wire        I_RESET,
	// APB
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [11:0] I_PADDR,
	input  wire [31:0] I_PWDATA,
	output reg  [31:0] O_PRDATA,
	output reg         O_PREADY,
	output reg         O_PSLVERR,
	// Memory access stage
	input  wire        I_MEM_VALID,
	input  wire        I_MEM_WRITE,
	input  wire        I_MEM_IMPLICIT,
	input  wire [1:0]  I_MEM_SEG,
	input  wire [3:0]  I_MEM_TYPE,
	input  wire        I_MEM_OPSIZE32,
	input  wire [31:0] I_MEM_ADDR,
	input  wire [31:0] I_INSN_IP,
	input  wire [31:0] I_NEXT_IP,
	input  wire        I_ALIGN_FLAG,
	input  wire [1:0]  I_CPL,
	// Software interrupt instruction
	input  wire        I_SWINT_VALID,
	input  wire [7:0]  I_SWINT_VECTOR,
	// Machine error
	input  wire        I_MERR,
	input  wire        I_MERR_IP_TIED,
	// External maskable request
	input  wire        I_MASKABLE_INTERRUPT_REQUEST_REQ,
	input  wire [7:0]  I_MASKABLE_INTERRUPT_REQUEST_VECTOR,
	input  wire        I_PIPE_EMPTY,
	// Outputs to pipeline and memory
	output reg         O_MEM_WRITE_EN,
	output reg         O_SUPPRESS,
	output reg         O_EXC_VALID,
	output reg  [7:0]  O_EXC_VECTOR,
	output reg         O_EXC_HAS_ERR,
	output reg  [31:0] O_EXC_ERR_CODE,
	output reg  [31:0] O_EXC_SAVED_IP,
	output reg         O_EXC_ABORT,
	output reg         O_MASKABLE_INTERRUPT_REQUEST_ACK,
	output reg         O_SHUTDOWN,
	output reg         O_IRQ
);
	reg [1:0]  ctrl_r;
	reg [3:0]  status_r;
	reg [3:0]  mask_r;
	reg [1:0]  gstat_r;
	reg [31:0] saved_ip_r;
	reg [1:0]  log_wp_r;
	reg [1:0]  log_rp_r;
	reg        rd_pend_r;
	reg        shut_r;
	reg        maskable_interrupt_request_pend_r;
	wire [39:0] log_rdata;

	// Boundary minus one for the operand type, as a low address mask
	function [2:0] align_mask;
		input [3:0] dtype;
		input       opsize32;
		begin
			case (dtype)
				`CXC_DT_WORD:   align_mask = 3'h1;
				`CXC_DT_DWORD:  align_mask = 3'h3;
				`CXC_DT_SREAL:  align_mask = 3'h3;
				`CXC_DT_DREAL:  align_mask = 3'h7;
				`CXC_DT_XREAL:  align_mask = 3'h7;
				`CXC_DT_SEL:    align_mask = 3'h1;
				`CXC_DT_FP32:   align_mask = 3'h1;
				`CXC_DT_FP48:   align_mask = 3'h3;
				`CXC_DT_PTR32:  align_mask = 3'h3;
				`CXC_DT_TBLREG: align_mask = 3'h3;
				`CXC_DT_FENV,
				`CXC_DT_FPU_STATE_SAVE,
				`CXC_DT_BITSTR: align_mask = opsize32 ? 3'h3 : 3'h1;
				default:        align_mask = 3'h0;
			endcase
		end
	endfunction

	// Register decode is used by the read path and the write path
	function is_addr;
		input [11:0] addr;
		input [11:0] reg_off;
		begin
			is_addr = (addr == reg_off);
		end
	endfunction

	wire seg_checked = (I_MEM_SEG == `CXC_SEG_DATA) || (I_MEM_SEG == `CXC_SEG_STACK);
	wire chk_enable  = ctrl_r[`CXC_CTRL_AM_BIT] && I_ALIGN_FLAG && (I_CPL == `CXC_CPL_USER);
	wire misaligned  = |(I_MEM_ADDR[2:0] & align_mask(I_MEM_TYPE, I_MEM_OPSIZE32));
	// Implicit accesses run at level 0 whatever the instruction level
	wire align_fault = I_MEM_VALID && !I_MEM_IMPLICIT && seg_checked && chk_enable && misaligned;

	wire swint_ok = I_SWINT_VALID && (I_SWINT_VECTOR >= `CXC_VEC_USER_MIN);
	wire maskable_interrupt_request_ok  = I_MASKABLE_INTERRUPT_REQUEST_VECTOR >= `CXC_VEC_USER_MIN;
	// External request waits for a drained pipeline; faults and software ints go first
	wire maskable_interrupt_request_take = maskable_interrupt_request_pend_r && maskable_interrupt_request_ok && I_PIPE_EMPTY && !align_fault && !I_MERR && !I_SWINT_VALID;

	wire apb_acc  = I_PSEL && I_PENABLE && !O_PREADY;
	// A transfer completes at the edge where the master sees ready high
	wire apb_done = I_PSEL && I_PENABLE && O_PREADY;
	wire apb_wr   = apb_done && I_PWRITE;
	wire wr_stat  = apb_wr && is_addr(I_PADDR, `CXC_REG_STATUS);

	wire [3:0] ev_set = {maskable_interrupt_request_take, I_MERR && !ctrl_r[`CXC_CTRL_MCE_BIT], I_MERR && ctrl_r[`CXC_CTRL_MCE_BIT],
		align_fault};
	wire [3:0] ev_clr = wr_stat ? I_PWDATA[3:0] : 4'h0;

	wire known_addr = is_addr(I_PADDR, `CXC_REG_CTRL) || is_addr(I_PADDR, `CXC_REG_STATUS) ||
		is_addr(I_PADDR, `CXC_REG_MASK) || is_addr(I_PADDR, `CXC_REG_GSTAT) ||
		is_addr(I_PADDR, `CXC_REG_EVENT) || is_addr(I_PADDR, `CXC_REG_SAVED_IP) ||
		is_addr(I_PADDR, `CXC_REG_LOG_ADDR);

	// Log only faults that are delivered, so the entry matches the advancing write pointer
	wire log_we = align_fault && !I_MERR && !shut_r;

	cxc_log_mem u_log (
		.i_clk   (I_CLK_SYS),
		.i_we    (log_we),
		.i_waddr (log_wp_r),
		.i_wdata ({4'h0, I_MEM_TYPE, I_MEM_ADDR}),
		.i_raddr (log_rp_r),
		.o_rdata (log_rdata)
	);

	// Sticky status: a new event wins over a simultaneous clear
	genvar g;
	generate
		for (g = 0; g < `CXC_EV_W; g = g + 1) begin : g_stat
			always @(posedge I_CLK_SYS or posedge I_RESET) begin
				if (I_RESET) begin
					status_r[g] <= 1'b0;
				end else if (ev_set[g]) begin
					status_r[g] <= 1'b1;
				end else if (ev_clr[g]) begin
					status_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Exception delivery and pipeline controls
	always @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			O_MEM_WRITE_EN <= 1'b0;
			O_SUPPRESS     <= 1'b0;
			O_EXC_VALID    <= 1'b0;
			O_EXC_VECTOR   <= 8'h00;
			O_EXC_HAS_ERR  <= 1'b0;
			O_EXC_ERR_CODE <= 32'h0000_0000;
			O_EXC_SAVED_IP <= 32'h0000_0000;
			O_EXC_ABORT    <= 1'b0;
			O_MASKABLE_INTERRUPT_REQUEST_ACK     <= 1'b0;
			shut_r         <= 1'b0;
			maskable_interrupt_request_pend_r    <= 1'b0;
			gstat_r        <= 2'h0;
			saved_ip_r     <= 32'h0000_0000;
			log_wp_r       <= 2'h0;
		end else begin
			// Write strobe is gated in the same cycle as the check, so no faulting byte lands
			O_MEM_WRITE_EN <= I_MEM_VALID && I_MEM_WRITE && !align_fault && !shut_r;
			O_SUPPRESS     <= align_fault || I_MERR;
			O_EXC_VALID    <= 1'b0;
			O_EXC_ABORT    <= 1'b0;
			O_MASKABLE_INTERRUPT_REQUEST_ACK     <= 1'b0;
			// Out-of-range external vectors are dropped, not delivered
			// The source drops its request one cycle after the acknowledge; do not re-arm then
			maskable_interrupt_request_pend_r    <= I_MASKABLE_INTERRUPT_REQUEST_REQ && maskable_interrupt_request_ok && !maskable_interrupt_request_take && !O_MASKABLE_INTERRUPT_REQUEST_ACK;
			if (shut_r) begin
				O_EXC_VALID <= 1'b0;
			end else if (I_MERR) begin
				gstat_r[`CXC_GSTAT_SAVED_POINTER_VALID_BIT] <= I_MERR_IP_TIED;
				gstat_r[`CXC_GSTAT_IP_BIT]   <= 1'b1;
				saved_ip_r <= I_INSN_IP;
				if (ctrl_r[`CXC_CTRL_MCE_BIT]) begin
					O_EXC_VALID    <= 1'b1;
					O_EXC_ABORT    <= 1'b1;
					O_EXC_VECTOR   <= `CXC_VEC_MCHK;
					O_EXC_HAS_ERR  <= 1'b0;
					O_EXC_ERR_CODE <= 32'h0000_0000;
					O_EXC_SAVED_IP <= I_INSN_IP;
				end else begin
					shut_r <= 1'b1;
				end
			end else if (align_fault) begin
				O_EXC_VALID    <= 1'b1;
				O_EXC_VECTOR   <= `CXC_VEC_ALIGN;
				O_EXC_HAS_ERR  <= 1'b1;
				O_EXC_ERR_CODE <= 32'h0000_0000;
				O_EXC_SAVED_IP <= I_INSN_IP;
				log_wp_r       <= log_wp_r + 2'h1;
			end else if (swint_ok) begin
				O_EXC_VALID    <= 1'b1;
				O_EXC_VECTOR   <= I_SWINT_VECTOR;
				O_EXC_HAS_ERR  <= 1'b0;
				O_EXC_ERR_CODE <= 32'h0000_0000;
				O_EXC_SAVED_IP <= I_NEXT_IP;
			end else if (maskable_interrupt_request_take) begin
				O_EXC_VALID    <= 1'b1;
				O_MASKABLE_INTERRUPT_REQUEST_ACK     <= 1'b1;
				O_EXC_VECTOR   <= I_MASKABLE_INTERRUPT_REQUEST_VECTOR;
				O_EXC_HAS_ERR  <= 1'b0;
				O_EXC_ERR_CODE <= 32'h0000_0000;
				O_EXC_SAVED_IP <= I_NEXT_IP;
			end
		end
	end

	always @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			O_SHUTDOWN <= 1'b0;
			O_IRQ      <= 1'b0;
		end else begin
			O_SHUTDOWN <= shut_r;
			O_IRQ      <= |(status_r & mask_r);
		end
	end

	// APB slave: two wait states on every read and write so log data comes from the memory register
	always @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			ctrl_r    <= `CXC_CTRL_RESET;
			mask_r    <= 4'h0;
			log_rp_r  <= 2'h0;
			rd_pend_r <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
			if (apb_acc && !rd_pend_r) begin
				rd_pend_r <= 1'b1;
			end else if (rd_pend_r) begin
				rd_pend_r <= 1'b0;
				O_PREADY  <= 1'b1;
				O_PSLVERR <= !known_addr;
				O_PRDATA  <= 32'h0000_0000;
				if (!I_PWRITE) begin
					if (is_addr(I_PADDR, `CXC_REG_CTRL)) O_PRDATA <= {30'h0, ctrl_r};
					if (is_addr(I_PADDR, `CXC_REG_STATUS)) O_PRDATA <= {28'h0, status_r};
					if (is_addr(I_PADDR, `CXC_REG_MASK)) O_PRDATA <= {28'h0, mask_r};
					if (is_addr(I_PADDR, `CXC_REG_GSTAT)) O_PRDATA <= {30'h0, gstat_r};
					if (is_addr(I_PADDR, `CXC_REG_EVENT)) O_PRDATA <= log_rdata[31:0];
					if (is_addr(I_PADDR, `CXC_REG_SAVED_IP)) O_PRDATA <= saved_ip_r;
					if (is_addr(I_PADDR, `CXC_REG_LOG_ADDR)) O_PRDATA <= {24'h0, log_rdata[35:32], 2'h0, log_rp_r};
				end
			end
			// Writes land only at the completing edge, never while the access is still waiting
			if (apb_wr) begin
				if (is_addr(I_PADDR, `CXC_REG_CTRL)) begin
					ctrl_r <= I_PWDATA[1:0];
				end
				if (is_addr(I_PADDR, `CXC_REG_MASK)) begin
					mask_r <= I_PWDATA[3:0];
				end
				if (is_addr(I_PADDR, `CXC_REG_LOG_ADDR)) begin
					log_rp_r <= I_PWDATA[1:0];
				end
			end
		end
	end
endmodule

// file: core/cxc_pad.v
// Holds no logic: the exception unit needs no pad cells

// file: tb/cxc_asserts.sv
// Port checker for the exception unit
`timescale 1ns/1ps
`include "cxc_defs.vh"
module cxc_asserts (
	input wire        I_CLK_SYS,
	input wire        I_RESET,
	input wire        I_MEM_VALID,
	input wire        I_MEM_IMPLICIT,
	input wire [1:0]  I_MEM_SEG,
	input wire [1:0]  I_CPL,
	input wire [31:0] I_INSN_IP,
	input wire [31:0] I_NEXT_IP,
	input wire        I_SWINT_VALID,
	input wire [7:0]  I_SWINT_VECTOR,
	input wire        I_MERR,
	input wire        I_PIPE_EMPTY,
	input wire        O_MEM_WRITE_EN,
	input wire        O_SUPPRESS,
	input wire        O_EXC_VALID,
	input wire [7:0]  O_EXC_VECTOR,
	input wire        O_EXC_HAS_ERR,
	input wire [31:0] O_EXC_ERR_CODE,
	input wire [31:0] O_EXC_SAVED_IP,
	input wire        O_EXC_ABORT,
	input wire        O_MASKABLE_INTERRUPT_REQUEST_ACK,
	input wire        O_SHUTDOWN
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);
	wire al = O_EXC_VALID && O_EXC_VECTOR == `CXC_VEC_ALIGN;
	property p_seg; I_MEM_VALID && I_MEM_SEG[1] |=> !al; endproperty
	a_seg: assert property (p_seg) else $error("code or system access faulted");
	property p_cpl; I_MEM_VALID && I_CPL != 2'h3 |=> !al; endproperty
	a_cpl: assert property (p_cpl) else $error("fault outside user level");
	property p_imp; I_MEM_VALID && I_MEM_IMPLICIT |=> !al; endproperty
	a_imp: assert property (p_imp) else $error("implicit access faulted");
	property p_code; al |-> O_EXC_HAS_ERR && O_EXC_ERR_CODE == 0 && O_EXC_SAVED_IP == $past(I_INSN_IP); endproperty
	a_code: assert property (p_code) else $error("bad alignment fault frame");
	property p_kill; al |-> O_SUPPRESS && !O_MEM_WRITE_EN; endproperty
	a_kill: assert property (p_kill) else $error("faulting write not killed");
	property p_mc; O_EXC_VALID && O_EXC_VECTOR == 8'h12 |-> O_EXC_ABORT && !O_EXC_HAS_ERR; endproperty
	a_mc: assert property (p_mc) else $error("bad machine abort frame");
	property p_sw;
		I_SWINT_VALID && I_SWINT_VECTOR >= 8'h20 && !I_MERR && !I_MEM_VALID && !O_SHUTDOWN |=> O_EXC_VALID
		&& O_EXC_VECTOR == $past(I_SWINT_VECTOR) && !O_EXC_HAS_ERR && O_EXC_SAVED_IP == $past(I_NEXT_IP);
	endproperty
	a_sw: assert property (p_sw) else $error("software vector not delivered");
	property p_shut; O_SHUTDOWN |=> O_SHUTDOWN && !O_EXC_VALID; endproperty
	a_shut: assert property (p_shut) else $error("shutdown left");
	property p_ack; O_MASKABLE_INTERRUPT_REQUEST_ACK |-> $past(I_PIPE_EMPTY) && O_EXC_VECTOR >= 8'h20 && !O_EXC_HAS_ERR; endproperty
	a_ack: assert property (p_ack) else $error("external request taken early");
	c_al: cover property (al);
	c_mc: cover property (O_EXC_ABORT);
	c_ack: cover property (O_MASKABLE_INTERRUPT_REQUEST_ACK);
	c_shut: cover property (O_SHUTDOWN);
endmodule
bind cxc_exc_unit cxc_asserts i_cxc_asserts (.I_CLK_SYS, .I_RESET, .I_MEM_VALID, .I_MEM_IMPLICIT, .I_MEM_SEG, .I_CPL,
	.I_INSN_IP, .I_NEXT_IP, .I_SWINT_VALID, .I_SWINT_VECTOR, .I_MERR, .I_PIPE_EMPTY, .O_MEM_WRITE_EN, .O_SUPPRESS,
	.O_EXC_VALID, .O_EXC_VECTOR, .O_EXC_HAS_ERR, .O_EXC_ERR_CODE, .O_EXC_SAVED_IP, .O_EXC_ABORT, .O_MASKABLE_INTERRUPT_REQUEST_ACK,
	.O_SHUTDOWN);

// file: tb/cxc_maskable_interrupt_request_src.sv
// External maskable request source model
`timescale 1ns/1ps
module cxc_maskable_interrupt_request_src (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_go,
	input  wire [7:0]  i_vec,
	input  wire        i_ack,
	output logic       o_req,
	output logic [7:0] o_vec
);
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_req <= 1'b0;
			o_vec <= 8'h00;
		end else if (i_ack) begin
			o_req <= 1'b0;
			o_vec <= ~o_vec; // Released vector shows its inverse, so stale reuse is caught
		end else if (i_go && !o_req) begin
			o_req <= 1'b1;
			o_vec <= i_vec;
		end
	end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the exception unit
`timescale 1ns/1ps
`include "cxc_defs.vh"
module tb_top;
	logic        clk, rst, psel, pen, pwr, mv, imp, op, af, merr, tied, pe, swv, go, se;
	logic [1:0]  seg, current_privilege_level;
	logic [3:0]  typ;
	logic [7:0]  swvec, gvec, ivec, vec;
	logic [11:0] pa;
	logic [31:0] pwd, rd, ma, prd, ec, sip;
	logic        rdy, err, wen, sup, ev, he, ab, ack, sd, irq, ireq;
	int          bad_count, compares, acks, t;
	// Row: segment, type, operand size 32 and address low bits, fault expected
	logic [15:0] rows [19] = '{16'h0111, 16'h1221, 16'h0240, 16'h0441, 16'h0500, 16'h2110, 16'h3210, 16'h0611,
		16'h0720, 16'h0821, 16'h0921, 16'h0a21, 16'h0ba1, 16'h0b20, 16'h0c11, 16'h0da1, 16'h0d20, 16'h0010, 16'h0361};
	cxc_exc_unit i_cxc_exc_unit (.I_CLK_SYS(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .I_MEM_VALID(mv),
		.I_MEM_WRITE(1'b1), .I_MEM_IMPLICIT(imp), .I_MEM_SEG(seg), .I_MEM_TYPE(typ), .I_MEM_OPSIZE32(op),
		.I_MEM_ADDR(ma), .I_INSN_IP(32'h1000), .I_NEXT_IP(32'h1004), .I_ALIGN_FLAG(af), .I_CPL(current_privilege_level),
		.I_SWINT_VALID(swv), .I_SWINT_VECTOR(swvec), .I_MERR(merr), .I_MERR_IP_TIED(tied), .I_MASKABLE_INTERRUPT_REQUEST_REQ(ireq),
		.I_MASKABLE_INTERRUPT_REQUEST_VECTOR(ivec), .I_PIPE_EMPTY(pe), .O_MEM_WRITE_EN(wen), .O_SUPPRESS(sup), .O_EXC_VALID(ev),
		.O_EXC_VECTOR(vec), .O_EXC_HAS_ERR(he), .O_EXC_ERR_CODE(ec), .O_EXC_SAVED_IP(sip), .O_EXC_ABORT(ab),
		.O_MASKABLE_INTERRUPT_REQUEST_ACK(ack), .O_SHUTDOWN(sd), .O_IRQ(irq));
	cxc_maskable_interrupt_request_src i_cxc_maskable_interrupt_request_src (.i_clk(clk), .i_rst(rst), .i_go(go), .i_vec(gvec), .i_ack(ack), .o_req(ireq),
		.o_vec(ivec));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (ack === 1'b1) acks++;
	task automatic finish_test;
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [47:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (rdy !== 1'b1 && t < 20);
		if (rdy !== 1'b1)
			bad_count++;
		rd = prd;
		se = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic acc(input logic [15:0] r, input logic f, input logic [1:0] c, input logic i);
		@(posedge clk);
		mv <= 1'b1;
		seg <= r[13:12];
		typ <= r[11:8];
		op <= r[7];
		ma <= {29'h00000080, r[6:4]};
		af <= f;
		current_privilege_level <= c;
		imp <= i;
		@(posedge clk);
		mv <= 1'b0;
		#1;
	endtask
	task automatic evt(input logic m, k, s, input logic [7:0] v);
		@(posedge clk);
		merr <= m;
		tied <= k;
		swv <= s;
		swvec <= v;
		@(posedge clk);
		merr <= 1'b0;
		swv <= 1'b0;
		#1;
	endtask
	initial begin
		{psel, pen, pwr, mv, imp, op, af, merr, tied, pe, swv, go, seg, current_privilege_level, typ, swvec, gvec, pa, pwd, ma} = '0;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(1'b1, `CXC_REG_CTRL, 32'h3);
		apb(1'b1, `CXC_REG_MASK, 32'hf);
		foreach (rows[k]) begin
			acc(rows[k], 1'b1, 2'h3, 1'b0);
			chk("align fault", rows[k][0], ev && vec === 8'h11);
			chk("write enable", !rows[k][0], wen);
		end
		chk("fault code", {1'b1, 32'h0}, {he, ec});
		chk("fault ip", 32'h1000, sip);
		chk("suppress", 1'b1, sup);
		apb(1'b0, `CXC_REG_STATUS, 32'h0);
		chk("status", 32'h1, rd);
		chk("irq", 1'b1, irq);
		apb(1'b1, `CXC_REG_STATUS, 32'h1);
		@(posedge clk);
		#1;
		chk("irq cleared", 1'b0, irq);
		apb(1'b1, `CXC_REG_MASK, 32'h0);
		acc(16'h0111, 1'b1, 2'h3, 1'b0);
		@(posedge clk);
		#1;
		chk("irq masked", 1'b0, irq);
		for (int k = 0; k < 3; k++) begin
			acc(16'h0111, k != 0, k == 1 ? 2'h0 : 2'h3, k == 2);
			chk("gated", 1'b0, ev);
		end
		apb(1'b1, `CXC_REG_CTRL, 32'h2);
		acc(16'h0111, 1'b1, 2'h3, 1'b0);
		chk("mask enable off", 1'b0, ev);
		apb(1'b0, 12'h1fc, 32'h0);
		chk("unmapped", 33'h100000000, {se, rd});
		evt(1'b0, 1'b0, 1'b1, 8'h20);
		chk("swint low", {1'b1, 8'h20, 1'b0, 32'h1004}, {ev, vec, he, sip});
		evt(1'b0, 1'b0, 1'b1, 8'hff);
		chk("swint high", {1'b1, 8'hff, 1'b0, 32'h1004}, {ev, vec, he, sip});
		evt(1'b0, 1'b0, 1'b1, 8'h1f);
		chk("swint refused", 1'b0, ev);
		@(posedge clk);
		go <= 1'b1;
		gvec <= 8'h80;
		@(posedge clk);
		go <= 1'b0;
		repeat (6) @(posedge clk);
		chk("held off", 0, acks);
		pe <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			#1;
			t++;
		end while (ack !== 1'b1 && t < 10);
		chk("external", {1'b1, 8'h80, 1'b0, 32'h1004}, {ev, vec, he, sip});
		apb(1'b0, `CXC_REG_STATUS, 32'h0);
		chk("status ext", 32'h9, rd);
		chk("one ack", 1, acks);
		apb(1'b1, `CXC_REG_CTRL, 32'h3);
		evt(1'b1, 1'b1, 1'b0, 8'h00);
		chk("abort", {1'b1, 8'h12, 1'b1, 1'b0}, {ev, vec, ab, he});
		apb(1'b0, `CXC_REG_GSTAT, 32'h0);
		chk("pointer valid", 1'b1, rd[0]);
		evt(1'b1, 1'b0, 1'b0, 8'h00);
		apb(1'b0, `CXC_REG_GSTAT, 32'h0);
		chk("pointer not tied", 1'b0, rd[0]);
		apb(1'b1, `CXC_REG_CTRL, 32'h1);
		evt(1'b1, 1'b0, 1'b0, 8'h00);
		chk("shutdown", 2'h0, {ev, ab});
		evt(1'b0, 1'b0, 1'b1, 8'h40);
		chk("shut state", 2'h2, {sd, ev});
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("reset shutdown", 1'b0, sd);
		apb(1'b0, `CXC_REG_CTRL, 32'h0);
		chk("reset ctrl", `CXC_CTRL_RESET, rd);
		finish_test;
	end
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		finish_test;
	end
endmodule
